// File: cic_pkg.sv
package cic_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PC_W = 15;

    // Register offsets.
    localparam logic [7:0] OFF_IRQ_CONTROL = 8'h00;
    localparam logic [7:0] OFF_OPTION = 8'h01;
    localparam logic [7:0] OFF_SHD_STATUS = 8'h04;
    localparam logic [7:0] OFF_SHD_W = 8'h05;
    localparam logic [7:0] OFF_SHD_BSR = 8'h06;
    localparam logic [7:0] OFF_SHD_PC_HIGH_LATCH = 8'h07;
    localparam logic [7:0] OFF_SHD_FSR0L = 8'h08;
    localparam logic [7:0] OFF_SHD_FSR0H = 8'h09;
    localparam logic [7:0] OFF_SHD_FSR1L = 8'h0A;
    localparam logic [7:0] OFF_SHD_FSR1H = 8'h0B;

    // Control and option register fields.
    localparam int BIT_GIE = 7;
    localparam int BIT_PERIPHERAL_GROUP_ENABLE = 6;
    localparam int BIT_T0IE = 5;
    localparam int BIT_EXTIE = 4;
    localparam int BIT_PCIE = 3;
    localparam int BIT_T0IF = 2;
    localparam int BIT_EXTIF = 1;
    localparam int BIT_PCIF = 0;
    localparam int BIT_EDGE_SEL = 6;
    localparam logic [7:0] IRQ_CONTROL_RESET = 8'h00;

    // Context widths.
    localparam int STATUS_W = 3;
    localparam int BSR_W = 5;
    localparam int PC_HIGH_LATCH_W = 7;
    localparam int FSR_W = 16;

    localparam logic [PC_W-1:0] IRQ_VECTOR = 15'h0004;

    // Instruction cycle timing.
    localparam int CLK_PERIOD_NS = 100;
    localparam int TCY_NS = 400;
    localparam int TCY_CLKS = TCY_NS / CLK_PERIOD_NS;
    localparam logic [1:0] PHASE_LAST = 2'(TCY_CLKS - 1);
    localparam logic [1:0] PHASE_Q1 = 2'h0;
endpackage : cic_pkg

// File: cic_edge_detect.sv
`timescale 1ns/1ns
module cic_edge_detect (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pin,
    input wire logic rising_sel,
    output logic edge_pulse
);
    logic sync1;
    logic sync2;
    logic sync3;
    logic level;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end else begin
            sync1 <= pin;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // The filtered level moves only once the last two stages agree.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            level <= 1'b0;
            edge_pulse <= 1'b0;
        end else begin
            if (sync2 == sync3) begin
                level <= sync3;
            end
            edge_pulse <= (sync2 == sync3) && (sync3 != level) &&
                          (sync3 == rising_sel);
        end
    end
endmodule : cic_edge_detect

// File: cic_shadow_regs.sv
`timescale 1ns/1ns
module cic_shadow_regs (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic save,
    input wire logic [cic_pkg::STATUS_W-1:0] status_in,
    input wire logic [7:0] w_in,
    input wire logic [cic_pkg::BSR_W-1:0] bsr_in,
    input wire logic [cic_pkg::PC_HIGH_LATCH_W-1:0] pc_high_latch_in,
    input wire logic [cic_pkg::FSR_W-1:0] fsr0_in,
    input wire logic [cic_pkg::FSR_W-1:0] fsr1_in,
    input wire logic sw_wr,
    input wire logic [7:0] sw_addr,
    input wire logic [7:0] sw_data,
    output logic [cic_pkg::STATUS_W-1:0] shd_status,
    output logic [7:0] shd_w,
    output logic [cic_pkg::BSR_W-1:0] shd_bsr,
    output logic [cic_pkg::PC_HIGH_LATCH_W-1:0] shd_pc_high_latch,
    output logic [cic_pkg::FSR_W-1:0] shd_fsr0,
    output logic [cic_pkg::FSR_W-1:0] shd_fsr1
);
    // Entry capture takes priority over a software write in the same cycle.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            shd_status <= '0;
            shd_w <= '0;
            shd_bsr <= '0;
            shd_pc_high_latch <= '0;
            shd_fsr0 <= '0;
            shd_fsr1 <= '0;
        end else if (save) begin
            shd_status <= status_in;
            shd_w <= w_in;
            shd_bsr <= bsr_in;
            shd_pc_high_latch <= pc_high_latch_in;
            shd_fsr0 <= fsr0_in;
            shd_fsr1 <= fsr1_in;
        end else if (sw_wr) begin
            case (sw_addr)
                cic_pkg::OFF_SHD_STATUS: shd_status <= sw_data[cic_pkg::STATUS_W-1:0];
                cic_pkg::OFF_SHD_W: shd_w <= sw_data;
                cic_pkg::OFF_SHD_BSR: shd_bsr <= sw_data[cic_pkg::BSR_W-1:0];
                cic_pkg::OFF_SHD_PC_HIGH_LATCH: shd_pc_high_latch <= sw_data[cic_pkg::PC_HIGH_LATCH_W-1:0];
                cic_pkg::OFF_SHD_FSR0L: shd_fsr0[7:0] <= sw_data;
                cic_pkg::OFF_SHD_FSR0H: shd_fsr0[15:8] <= sw_data;
                cic_pkg::OFF_SHD_FSR1L: shd_fsr1[7:0] <= sw_data;
                cic_pkg::OFF_SHD_FSR1H: shd_fsr1[15:8] <= sw_data;
                default: begin
                end
            endcase
        end
    end
endmodule : cic_shadow_regs

// File: cic_core_interrupt_controller.sv
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
module cic_core_interrupt_controller (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic ext_int_pin,
    input wire logic timer0_ovf,
    input wire logic pin_change_any,
    input wire logic periph_req_1,
    input wire logic periph_req_2,
    input wire logic periph_wake_1,
    input wire logic periph_wake_2,
    input wire logic core_sleeping,
    input wire logic return_from_irq_instr_exec,
    input wire logic [cic_pkg::PC_W-1:0] pc_in,
    input wire logic [cic_pkg::STATUS_W-1:0] status_in,
    input wire logic [7:0] w_in,
    input wire logic [cic_pkg::BSR_W-1:0] bsr_in,
    input wire logic [cic_pkg::PC_HIGH_LATCH_W-1:0] pc_high_latch_in,
    input wire logic [cic_pkg::FSR_W-1:0] fsr0_in,
    input wire logic [cic_pkg::FSR_W-1:0] fsr1_in,
    output logic irq_flush,
    output logic irq_push_pc,
    output logic [cic_pkg::PC_W-1:0] irq_push_addr,
    output logic irq_load_pc,
    output logic [cic_pkg::PC_W-1:0] irq_vector_addr,
    output logic irq_pop_pc,
    output logic ctx_restore,
    output logic wake_req,
    output logic [cic_pkg::STATUS_W-1:0] shd_status,
    output logic [7:0] shd_w,
    output logic [cic_pkg::BSR_W-1:0] shd_bsr,
    output logic [cic_pkg::PC_HIGH_LATCH_W-1:0] shd_pc_high_latch,
    output logic [cic_pkg::FSR_W-1:0] shd_fsr0,
    output logic [cic_pkg::FSR_W-1:0] shd_fsr1
);
    logic [1:0] phase;
    logic q1;
    logic global_irq_enable;
    logic peripheral_group_enable;
    logic timer0_ovf_irq_en;
    logic ext_pin_irq_en;
    logic pin_change_irq_en;
    logic timer0_ovf_flag;
    logic ext_pin_irq_flag;
    logic pin_change_summary_flag;
    logic ext_edge_select;
    logic ext_edge;
    logic entry;
    logic post_wake_hold;
    logic irq_request;
    logic slept_ext_en;
    logic slept_pc_en;
    logic slept_group_en;
    logic ext_edge_pending;
    logic flag_window;
    logic wake_source;
    logic wr_ctrl;
    logic wr_opt;
    logic [7:0] irq_control_reg;
    logic [7:0] next_rdata;
    typedef enum logic [1:0] {WAKE_IDLE, WAKE_SLEPT, WAKE_FIRST} cic_wake_e;
    cic_wake_e wake_state;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    assign wr_ctrl = wr && hit(addr, cic_pkg::OFF_IRQ_CONTROL);
    assign wr_opt = wr && hit(addr, cic_pkg::OFF_OPTION);

    // Instruction cycle divider; q1 marks the first phase of each cycle.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            phase <= cic_pkg::PHASE_Q1;
            q1 <= 1'b0;
        end else begin
            if (phase == cic_pkg::PHASE_LAST) begin
                phase <= cic_pkg::PHASE_Q1;
            end else begin
                phase <= phase + 2'h1;
            end
            q1 <= (phase == cic_pkg::PHASE_LAST);
        end
    end

    cic_edge_detect u_edge (
        .clk(clk),
        .rst_b(rst_b),
        .pin(ext_int_pin),
        .rising_sel(ext_edge_select),
        .edge_pulse(ext_edge)
    );

    // Request formed from flags and enables, with the group gate on peripherals.
    always_comb begin
        irq_request = global_irq_enable &&
            ((timer0_ovf_irq_en && timer0_ovf_flag) ||
             (ext_pin_irq_en && ext_pin_irq_flag) ||
             (pin_change_irq_en && pin_change_summary_flag) ||
             (peripheral_group_enable && (periph_req_1 || periph_req_2)));
    end

    // Timer0 runs from the system clock and so cannot wake the core.
    always_comb begin
        wake_source = (slept_ext_en && ext_pin_irq_flag) ||
            (slept_pc_en && pin_change_summary_flag) ||
            (slept_group_en && (periph_wake_1 || periph_wake_2));
    end

    // Enables are frozen while the core sleeps, so only sources armed before sleep wake it.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            slept_ext_en <= cic_pkg::IRQ_CONTROL_RESET[cic_pkg::BIT_EXTIE];
            slept_pc_en <= cic_pkg::IRQ_CONTROL_RESET[cic_pkg::BIT_PCIE];
            slept_group_en <= cic_pkg::IRQ_CONTROL_RESET[cic_pkg::BIT_PERIPHERAL_GROUP_ENABLE];
        end else if (!core_sleeping) begin
            slept_ext_en <= ext_pin_irq_en;
            slept_pc_en <= pin_change_irq_en;
            slept_group_en <= peripheral_group_enable;
        end
    end

    // Vectoring is decided only at Q1, whatever the current instruction is.
    assign entry = q1 && irq_request && !core_sleeping && !post_wake_hold;

    // Enable bits of the control register.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            peripheral_group_enable <= cic_pkg::IRQ_CONTROL_RESET[cic_pkg::BIT_PERIPHERAL_GROUP_ENABLE];
            timer0_ovf_irq_en <= cic_pkg::IRQ_CONTROL_RESET[cic_pkg::BIT_T0IE];
            ext_pin_irq_en <= cic_pkg::IRQ_CONTROL_RESET[cic_pkg::BIT_EXTIE];
            pin_change_irq_en <= cic_pkg::IRQ_CONTROL_RESET[cic_pkg::BIT_PCIE];
        end else if (wr_ctrl) begin
            peripheral_group_enable <= wdata[cic_pkg::BIT_PERIPHERAL_GROUP_ENABLE];
            timer0_ovf_irq_en <= wdata[cic_pkg::BIT_T0IE];
            ext_pin_irq_en <= wdata[cic_pkg::BIT_EXTIE];
            pin_change_irq_en <= wdata[cic_pkg::BIT_PCIE];
        end
    end

    // Global enable: hardware clears on entry and sets on return.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            global_irq_enable <= cic_pkg::IRQ_CONTROL_RESET[cic_pkg::BIT_GIE];
        end else if (entry) begin
            global_irq_enable <= 1'b0;
        end else if (return_from_irq_instr_exec) begin
            global_irq_enable <= 1'b1;
        end else if (wr_ctrl) begin
            global_irq_enable <= wdata[cic_pkg::BIT_GIE];
        end
    end

    // Sticky flags; an event in the clearing cycle wins over the clear.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            timer0_ovf_flag <= cic_pkg::IRQ_CONTROL_RESET[cic_pkg::BIT_T0IF];
            ext_pin_irq_flag <= cic_pkg::IRQ_CONTROL_RESET[cic_pkg::BIT_EXTIF];
        end else begin
            if (timer0_ovf) begin
                timer0_ovf_flag <= 1'b1;
            end else if (wr_ctrl) begin
                timer0_ovf_flag <= wdata[cic_pkg::BIT_T0IF];
            end
            if (flag_window && (ext_edge || ext_edge_pending)) begin
                ext_pin_irq_flag <= 1'b1;
            end else if (wr_ctrl) begin
                ext_pin_irq_flag <= wdata[cic_pkg::BIT_EXTIF];
            end
        end
    end

    // The pin flag is set only in the last or first phase; an edge elsewhere waits.
    assign flag_window = (phase == cic_pkg::PHASE_LAST) || (phase == cic_pkg::PHASE_Q1);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ext_edge_pending <= 1'b0;
        end else if (flag_window) begin
            ext_edge_pending <= 1'b0;
        end else if (ext_edge) begin
            ext_edge_pending <= 1'b1;
        end
    end

    // Summary follows the pin-change flags and ignores writes.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pin_change_summary_flag <= cic_pkg::IRQ_CONTROL_RESET[cic_pkg::BIT_PCIF];
        end else begin
            pin_change_summary_flag <= pin_change_any;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ext_edge_select <= 1'b0;
        end else if (wr_opt) begin
            ext_edge_select <= wdata[cic_pkg::BIT_EDGE_SEL];
        end
    end

    // Entry actions are issued together as one-cycle pulses to the core.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_flush <= 1'b0;
            irq_push_pc <= 1'b0;
            irq_push_addr <= '0;
            irq_load_pc <= 1'b0;
            irq_vector_addr <= cic_pkg::IRQ_VECTOR;
        end else begin
            irq_flush <= entry;
            irq_push_pc <= entry;
            irq_load_pc <= entry;
            irq_vector_addr <= cic_pkg::IRQ_VECTOR;
            if (entry) begin
                irq_push_addr <= pc_in;
            end
        end
    end

    // Return restores the shadowed context and pops the stack.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_pop_pc <= 1'b0;
            ctx_restore <= 1'b0;
        end else begin
            irq_pop_pc <= return_from_irq_instr_exec;
            ctx_restore <= return_from_irq_instr_exec;
        end
    end

    // Wake request to the core, one cycle after an armed source pends.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= core_sleeping && wake_source;
        end
    end

    // After a wake the instruction past the sleep runs before any vector.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wake_state <= WAKE_IDLE;
        end else begin
            case (wake_state)
                WAKE_IDLE: begin
                    if (core_sleeping && wake_source) begin
                        wake_state <= WAKE_SLEPT;
                    end
                end
                WAKE_SLEPT: begin
                    if (!core_sleeping && q1) begin
                        wake_state <= WAKE_FIRST;
                    end
                end
                WAKE_FIRST: begin
                    if (core_sleeping && wake_source) begin
                        wake_state <= WAKE_SLEPT;
                    end else if (!core_sleeping && q1) begin
                        wake_state <= WAKE_IDLE;
                    end
                end
                default: begin
                    wake_state <= WAKE_IDLE;
                end
            endcase
        end
    end

    assign post_wake_hold = (wake_state != WAKE_IDLE);

    cic_shadow_regs u_shadow (
        .clk(clk),
        .rst_b(rst_b),
        .save(entry),
        .status_in(status_in),
        .w_in(w_in),
        .bsr_in(bsr_in),
        .pc_high_latch_in(pc_high_latch_in),
        .fsr0_in(fsr0_in),
        .fsr1_in(fsr1_in),
        .sw_wr(wr),
        .sw_addr(addr),
        .sw_data(wdata),
        .shd_status(shd_status),
        .shd_w(shd_w),
        .shd_bsr(shd_bsr),
        .shd_pc_high_latch(shd_pc_high_latch),
        .shd_fsr0(shd_fsr0),
        .shd_fsr1(shd_fsr1)
    );

    always_comb begin
        irq_control_reg = '0;
        irq_control_reg[cic_pkg::BIT_GIE] = global_irq_enable;
        irq_control_reg[cic_pkg::BIT_PERIPHERAL_GROUP_ENABLE] = peripheral_group_enable;
        irq_control_reg[cic_pkg::BIT_T0IE] = timer0_ovf_irq_en;
        irq_control_reg[cic_pkg::BIT_EXTIE] = ext_pin_irq_en;
        irq_control_reg[cic_pkg::BIT_PCIE] = pin_change_irq_en;
        irq_control_reg[cic_pkg::BIT_T0IF] = timer0_ovf_flag;
        irq_control_reg[cic_pkg::BIT_EXTIF] = ext_pin_irq_flag;
        irq_control_reg[cic_pkg::BIT_PCIF] = pin_change_summary_flag;
    end

    always_comb begin
        next_rdata = 8'h00;
        case (addr)
            cic_pkg::OFF_IRQ_CONTROL: next_rdata = irq_control_reg;
            cic_pkg::OFF_OPTION: next_rdata[cic_pkg::BIT_EDGE_SEL] = ext_edge_select;
            cic_pkg::OFF_SHD_STATUS: next_rdata = {5'h00, shd_status};
            cic_pkg::OFF_SHD_W: next_rdata = shd_w;
            cic_pkg::OFF_SHD_BSR: next_rdata = {3'h0, shd_bsr};
            cic_pkg::OFF_SHD_PC_HIGH_LATCH: next_rdata = {1'h0, shd_pc_high_latch};
            cic_pkg::OFF_SHD_FSR0L: next_rdata = shd_fsr0[7:0];
            cic_pkg::OFF_SHD_FSR0H: next_rdata = shd_fsr0[15:8];
            cic_pkg::OFF_SHD_FSR1L: next_rdata = shd_fsr1[7:0];
            cic_pkg::OFF_SHD_FSR1H: next_rdata = shd_fsr1[15:8];
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data is valid only in the cycle after the read strobe.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata <= 8'h00;
        end else if (rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule : cic_core_interrupt_controller

// File: cic_props.sv
`timescale 1ns/1ns
module cic_props (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic return_from_irq_instr_exec,
    input wire logic core_sleeping,
    input wire logic [cic_pkg::PC_W-1:0] pc_in,
    input wire logic [7:0] w_in,
    input wire logic [cic_pkg::STATUS_W-1:0] status_in,
    input wire logic irq_flush,
    input wire logic irq_push_pc,
    input wire logic irq_load_pc,
    input wire logic [cic_pkg::PC_W-1:0] irq_push_addr,
    input wire logic [cic_pkg::PC_W-1:0] irq_vector_addr,
    input wire logic irq_pop_pc,
    input wire logic ctx_restore,
    input wire logic wake_req,
    input wire logic [7:0] shd_w,
    input wire logic [cic_pkg::STATUS_W-1:0] shd_status
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_entry;
        irq_flush && irq_push_pc && irq_load_pc;
    endsequence
    sequence s_return;
        irq_pop_pc && ctx_restore;
    endsequence
    a_entry_together: assert property ((irq_flush || irq_push_pc || irq_load_pc) |-> s_entry)
        else $error("entry pulses not together");
    a_vector_fixed: assert property (irq_vector_addr == 15'h0004)
        else $error("vector address wrong");
    a_push_pc_value: assert property (irq_push_pc |-> irq_push_addr == $past(pc_in))
        else $error("pushed address wrong");
    a_context_saved: assert property (irq_flush |-> shd_w == $past(w_in) && shd_status == $past(status_in))
        else $error("context not saved on entry");
    a_return_steps: assert property (return_from_irq_instr_exec |=> s_return)
        else $error("return did not pop and restore");
    a_return_cause: assert property ((irq_pop_pc || ctx_restore) |-> $past(return_from_irq_instr_exec))
        else $error("pop without return");
    a_entry_spacing: assert property (irq_flush |=> !irq_flush [*3])
        else $error("entries closer than one instruction cycle");
    a_sleep_no_entry: assert property ($past(core_sleeping) |-> !irq_flush)
        else $error("entry while sleeping");
    a_wake_sleep_only: assert property (wake_req |-> $past(core_sleeping))
        else $error("wake request while awake");
    a_read_stands: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside read cycle");
endmodule : cic_props

bind cic_core_interrupt_controller cic_props u_props (.clk(clk), .rst_b(rst_b), .rd(rd),
    .rdata(rdata), .return_from_irq_instr_exec(return_from_irq_instr_exec), .core_sleeping(core_sleeping), .pc_in(pc_in),
    .w_in(w_in), .status_in(status_in), .irq_flush(irq_flush), .irq_push_pc(irq_push_pc),
    .irq_load_pc(irq_load_pc), .irq_push_addr(irq_push_addr), .irq_vector_addr(irq_vector_addr),
    .irq_pop_pc(irq_pop_pc), .ctx_restore(ctx_restore), .wake_req(wake_req), .shd_w(shd_w),
    .shd_status(shd_status));

// File: cic_core_model.sv
`timescale 1ns/1ns
module cic_core_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ret_go,
    input wire logic irq_push_pc,
    input wire logic irq_load_pc,
    input wire logic irq_pop_pc,
    output logic return_from_irq_instr_exec,
    output logic [cic_pkg::PC_W-1:0] pc_in,
    output logic [cic_pkg::PC_W-1:0] prev_pc,
    output logic [cic_pkg::PC_W-1:0] ret_addr,
    output logic [cic_pkg::STATUS_W-1:0] status_in,
    output logic [7:0] w_in,
    output logic [cic_pkg::BSR_W-1:0] bsr_in,
    output logic [cic_pkg::PC_HIGH_LATCH_W-1:0] pc_high_latch_in,
    output logic [cic_pkg::FSR_W-1:0] fsr0_in,
    output logic [cic_pkg::FSR_W-1:0] fsr1_in
);
    // The core steps its PC every cycle, so live context differs at every entry.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pc_in <= 15'h0000;
            prev_pc <= 15'h0000;
            ret_addr <= 15'h0000;
            return_from_irq_instr_exec <= 1'b0;
        end else begin
            prev_pc <= pc_in;
            return_from_irq_instr_exec <= ret_go;
            if (irq_push_pc) ret_addr <= prev_pc;
            if (irq_load_pc) pc_in <= cic_pkg::IRQ_VECTOR;
            else if (irq_pop_pc) pc_in <= ret_addr;
            else pc_in <= pc_in + 15'h0001;
        end
    end
    assign w_in = pc_in[7:0] ^ 8'h5A;
    assign status_in = pc_in[2:0];
    assign bsr_in = pc_in[4:0];
    assign pc_high_latch_in = pc_in[14:8];
    assign fsr0_in = 16'(pc_in);
    assign fsr1_in = ~16'(pc_in);
endmodule : cic_core_model

// File: testbench.sv
`timescale 1ns/1ns
module testbench;
    localparam logic [7:0] CTL = cic_pkg::OFF_IRQ_CONTROL;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, shd_w;
    logic wr = 1'b0, rd = 1'b0, ext_int_pin = 1'b0, timer0_ovf = 1'b0, pin_change_any = 1'b0;
    logic periph_req_1 = 1'b0, periph_req_2 = 1'b0, periph_wake_1 = 1'b0, periph_wake_2 = 1'b0;
    logic core_sleeping = 1'b0, ret_go = 1'b0, return_from_irq_instr_exec, irq_flush, irq_push_pc, irq_load_pc;
    logic irq_pop_pc, ctx_restore, wake_req;
    logic [cic_pkg::PC_W-1:0] pc_in, prev_pc, ret_addr, irq_push_addr, irq_vector_addr, pc_save;
    logic [cic_pkg::STATUS_W-1:0] status_in, shd_status;
    logic [cic_pkg::BSR_W-1:0] bsr_in, shd_bsr;
    logic [cic_pkg::PC_HIGH_LATCH_W-1:0] pc_high_latch_in, shd_pc_high_latch;
    logic [cic_pkg::FSR_W-1:0] fsr0_in, fsr1_in, shd_fsr0, shd_fsr1;
    logic [7:0] w_in;
    int err_total = 0;
    int num_checks = 0;
    int n;

    cic_core_interrupt_controller DUT (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata,
        .ext_int_pin, .timer0_ovf, .pin_change_any, .periph_req_1, .periph_req_2,
        .periph_wake_1, .periph_wake_2, .core_sleeping, .return_from_irq_instr_exec, .pc_in, .status_in,
        .w_in, .bsr_in, .pc_high_latch_in, .fsr0_in, .fsr1_in, .irq_flush, .irq_push_pc,
        .irq_push_addr, .irq_load_pc, .irq_vector_addr, .irq_pop_pc, .ctx_restore,
        .wake_req, .shd_status, .shd_w, .shd_bsr, .shd_pc_high_latch, .shd_fsr0, .shd_fsr1);
    cic_core_model core (.clk, .rst_b, .ret_go, .irq_push_pc, .irq_load_pc, .irq_pop_pc,
        .return_from_irq_instr_exec, .pc_in, .prev_pc, .ret_addr, .status_in, .w_in, .bsr_in, .pc_high_latch_in,
        .fsr0_in, .fsr1_in);

    initial forever #50 clk = ~clk;

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk_val(16'(rdata), 16'(exp));
    endtask : rd_reg

    task automatic wait_flush(input int lim, output int cnt);
        cnt = 0;
        do begin
            @(posedge clk);
            #1 cnt++;
            if (cnt > lim) begin
                err_total++;
                stop_test();
            end
        end while (irq_flush !== 1'b1);
    endtask : wait_flush

    task automatic no_flush(input int cycles);
        repeat (cycles) begin
            @(posedge clk);
            #1 chk_val(16'(irq_flush), 16'h0000);
        end
    endtask : no_flush

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        stop_test();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(CTL, 8'h00);
        rd_reg(8'h3C, 8'h00);
        wr_reg(CTL, 8'h7F);
        rd_reg(CTL, 8'h7E);
        @(posedge clk) pin_change_any <= 1'b1;
        rd_reg(CTL, 8'h7F);
        @(posedge clk) pin_change_any <= 1'b0;
        rd_reg(CTL, 8'h7E);
        no_flush(12);
        wr_reg(CTL, 8'h20);
        @(posedge clk) timer0_ovf <= 1'b1;
        @(posedge clk) timer0_ovf <= 1'b0;
        rd_reg(CTL, 8'h24);
        no_flush(8);
        wr_reg(CTL, 8'hA4);
        wait_flush(8, n);
        chk_val(16'(irq_push_addr), 16'(prev_pc));
        chk_val(16'(irq_vector_addr), 16'h0004);
        chk_val(16'(shd_w), 16'(prev_pc[7:0] ^ 8'h5A));
        chk_val(16'(shd_bsr), 16'(prev_pc[4:0]));
        chk_val(shd_fsr1, ~16'(prev_pc));
        pc_save = prev_pc;
        rd_reg(CTL, 8'h24);
        rd_reg(cic_pkg::OFF_SHD_PC_HIGH_LATCH, {1'b0, pc_save[14:8]});
        rd_reg(cic_pkg::OFF_SHD_FSR0L, pc_save[7:0]);
        wr_reg(CTL, 8'h20);
        wr_reg(cic_pkg::OFF_SHD_W, 8'hC3);
        rd_reg(cic_pkg::OFF_SHD_W, 8'hC3);
        @(posedge clk) ret_go <= 1'b1;
        @(posedge clk) ret_go <= 1'b0;
        @(posedge clk);
        #1 chk_val(16'(irq_pop_pc), 16'h0001);
        chk_val(16'(shd_w), 16'h00C3);
        rd_reg(CTL, 8'hA0);
        no_flush(12);
        @(posedge clk) timer0_ovf <= 1'b1;
        @(posedge clk) timer0_ovf <= 1'b0;
        wait_flush(8, n);
        rd_reg(CTL, 8'h24);
        wr_reg(cic_pkg::OFF_OPTION, 8'h40);
        wr_reg(CTL, 8'h90);
        @(posedge clk) ext_int_pin <= 1'b1;
        wait_flush(16, n);
        rd_reg(CTL, 8'h12);
        wr_reg(CTL, 8'h10);
        wr_reg(cic_pkg::OFF_OPTION, 8'h00);
        @(posedge clk) ext_int_pin <= 1'b0;
        no_flush(12);
        rd_reg(CTL, 8'h12);
        wr_reg(CTL, 8'h10);
        @(posedge clk) ext_int_pin <= 1'b1;
        no_flush(12);
        rd_reg(CTL, 8'h10);
        wr_reg(CTL, 8'h80);
        @(posedge clk) periph_req_1 <= 1'b1;
        no_flush(12);
        wr_reg(CTL, 8'hC0);
        wait_flush(8, n);
        wr_reg(CTL, 8'h00);
        @(posedge clk) core_sleeping <= 1'b1;
        periph_wake_1 <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk_val(16'(wake_req), 16'h0000);
        wr_reg(CTL, 8'h40);
        repeat (2) @(posedge clk);
        #1 chk_val(16'(wake_req), 16'h0000);
        @(posedge clk) core_sleeping <= 1'b0;
        @(posedge clk) core_sleeping <= 1'b1;
        wr_reg(CTL, 8'hC0);
        #1 chk_val(16'(wake_req), 16'h0001);
        no_flush(8);
        @(posedge clk) core_sleeping <= 1'b0;
        periph_wake_1 <= 1'b0;
        wait_flush(12, n);
        chk_val(16'(n > 4), 16'h0001);
        rd_reg(CTL, 8'h40);
        @(posedge clk) rst_b <= 1'b0;
        @(posedge clk) rst_b <= 1'b1;
        rd_reg(CTL, 8'h00);
        stop_test();
    end
endmodule : testbench
